//--- inc/sci_pkg.sv
// Behaviour
// - While logging, store the first scan, then a scan only when pressure moved by the set increment.
// - Time command loads the clock with 24-hour hh:mm:ss.hh.
// - Date command loads the calendar as month, day, year.
// - Dump sends all logged scans, each session led by a new-cast mark.
// - Memory clear erases every logged scan.
// - Memory status reports absent memory or percentage used.
// - Detect setting takes two hex digits: attempt count then default rate code.
// - At power up try baud detection up to the count; zero skips it.
// - Rate codes 1,2 give 1200, then 2400 up to 38400 for 7.
// - Restore-defaults returns every setting to its factory value.
// - Receive disable makes later power ups ignore host characters; ignored characters still restart the idle timeout.
// - With receive disable, a return within 200 ms keeps reception on.
// - Receive enable makes later power ups accept host characters.
// - Idle timeout of 0 to 30 minutes enters logging; zero disables it.
// - Logging entered by timeout ends only at the next power up.
// - Scan waits the scan delay, in 20 ms steps, after each sample tick; ticks before sensor power-up or during a pending scan wait are dropped.
// - Sensors power up after the startup delay, in 20 ms steps.
// - Commands enable or disable the time and date fields of scans.
// - Analog off means no analog data is shown or logged.
// - One-channel shows channel 1, two-channel shows channels 1 and 2.
// - A header flag, set and cleared by commands, sends the header.
// - Commands take either case, end in return, accept short forms.
// - Link characters are eight data bits, no parity, one stop bit.
package sci_pkg;
   localparam int unsigned CLK_KHZ = 250_000;
   localparam int unsigned RXWIN_MS = 200;
   localparam int unsigned RXWIN_CYC = RXWIN_MS * CLK_KHZ;
   localparam int unsigned STEP_MS = 20;
   localparam int unsigned STEP_CYC = STEP_MS * CLK_KHZ;
   localparam longint unsigned MIN_MS = 60_000;
   localparam longint unsigned MIN_CYC = MIN_MS * CLK_KHZ;
   localparam logic [4:0] TMO_MAX = 5'h1E;
   localparam logic [7:0] HOUR_LIM = 8'h18;
   localparam logic [7:0] NUL = 8'h00;
   localparam logic [7:0] CASE_GAP = 8'h20;
   localparam logic [7:0] DEC = 8'h0A;
   localparam logic [3:0] HEX_ADJ = 4'h9;
   localparam logic [15:0] CENT = 16'h0064;
   localparam logic [15:0] TENTH = 16'h000A;
   localparam logic [15:0] BPS_1200 = 16'h04B0;
   localparam logic [15:0] BPS_2400 = 16'h0960;
   localparam logic [15:0] BPS_4800 = 16'h12C0;
   localparam logic [15:0] BPS_9600 = 16'h2580;
   localparam logic [15:0] BPS_19200 = 16'h4B00;
   localparam logic [15:0] BPS_38400 = 16'h9600;
   typedef struct packed {
      logic [15:0] inc_cent;
      logic [3:0] det_tries;
      logic [3:0] det_code;
      logic rx_off;
      logic [4:0] tmo_min;
      logic [7:0] scan_dly;
      logic [7:0] start_dly;
      logic show_time;
      logic show_date;
      logic ana_on;
      logic ana_two;
      logic hdr_on;
   } sci_cfg_s;
   localparam sci_cfg_s CFG_DEFAULT = '{
      inc_cent: 16'h0064, det_tries: 4'hA, det_code: 4'h5, rx_off: 1'b0,
      tmo_min: 5'h00, scan_dly: 8'h00, start_dly: 8'h00, show_time: 1'b1,
      show_date: 1'b1, ana_on: 1'b0, ana_two: 1'b0, hdr_on: 1'b1};
   typedef struct packed {
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
      logic [7:0] hund;
   } sci_clk_s;
   typedef struct packed {
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] year;
   } sci_date_s;
   typedef enum logic [1:0] {
      PH_INIT = 2'b00,
      PH_DET = 2'b01,
      PH_CMD = 2'b11,
      PH_LOG = 2'b10
   } sci_phase_e;
   typedef struct packed {
      sci_phase_e ph;
      sci_cfg_s cfg;
      logic [3:0] tries;
      logic rx_dis_act;
      logic rx_ign;
      logic [31:0] win;
      logic [2:0][31:0] wd;
      logic [1:0] wi;
      logic [2:0] ci;
      logic [3:0][7:0] fl;
      logic [1:0] fi;
      logic [1:0] fdig;
      logic [7:0] hx;
      logic [1:0] hxn;
      logic [31:0] spre;
      logic [7:0] dcnt;
      logic sens_on;
      logic scan_wait;
      logic [39:0] ipre;
      logic [4:0] imin;
      logic [15:0] last_p;
      logic have_p;
      logic scan_go;
      logic log_store;
      logic cast_mark;
      logic dump_go;
      logic clr_go;
      logic mstat_go;
      logic rtc_ld;
      logic cal_ld;
      logic hdr_go;
      logic prompt_go;
      sci_clk_s rtc;
      sci_date_s cal;
   } sci_st_s;
endpackage : sci_pkg

//--- logic/sci_cmd_interp.sv
`timescale 1ns/1ps
module sci_cmd_interp #(
   parameter int unsigned RXWIN_CYC = sci_pkg::RXWIN_CYC,
   parameter int unsigned STEP_CYC = sci_pkg::STEP_CYC,
   parameter longint unsigned MIN_CYC = sci_pkg::MIN_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic baud_fail,
   input wire logic baud_lock,
   input wire logic sample_tick,
   input wire logic press_valid,
   input wire logic [15:0] press_cent,
   input wire sci_pkg::sci_cfg_s nv_cfg,
   output sci_pkg::sci_cfg_s cfg,
   output logic det_busy,
   output logic [15:0] baud_bps,
   output logic rx_ignore,
   output logic logging,
   output logic sensor_pwr,
   output logic scan_go,
   output logic log_store,
   output logic cast_mark,
   output logic dump_go,
   output logic mem_clear_go,
   output logic mem_stat_go,
   output logic rtc_load,
   output sci_pkg::sci_clk_s rtc_set,
   output logic cal_load,
   output sci_pkg::sci_date_s cal_set,
   output logic hdr_go,
   output logic prompt_go,
   output logic ana1_en,
   output logic ana2_en
);
   import sci_pkg::*;

   sci_st_s s_q;
   sci_st_s s_d;

   function automatic logic [15:0] rate_of(input logic [3:0] code);
      logic [15:0] r;
      r = BPS_9600;
      unique case (code)
         4'h1, 4'h2: r = BPS_1200;
         4'h3: r = BPS_2400;
         4'h4: r = BPS_4800;
         4'h5: r = BPS_9600;
         4'h6: r = BPS_19200;
         4'h7: r = BPS_38400;
         default: r = BPS_9600;
      endcase
      return r;
   endfunction : rate_of

   always_comb begin
      logic [7:0] c;
      logic [7:0] d;
      logic [3:0] nib;
      logic is_dig;
      logic is_hex;
      logic busy;
      logic [7:0] tgt;
      logic [15:0] diff;
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      c = rx_byte;
      d = NUL;
      nib = 4'h0;
      is_dig = 1'b0;
      is_hex = 1'b0;
      busy = 1'b0;
      tgt = 8'h00;
      diff = 16'h0000;
      w0 = s_q.wd[0];
      w1 = s_q.wd[1];
      w2 = s_q.wd[2];
      s_d = s_q;
      s_d.scan_go = 1'b0;
      s_d.log_store = 1'b0;
      s_d.cast_mark = 1'b0;
      s_d.dump_go = 1'b0;
      s_d.clr_go = 1'b0;
      s_d.mstat_go = 1'b0;
      s_d.rtc_ld = 1'b0;
      s_d.cal_ld = 1'b0;
      s_d.hdr_go = 1'b0;
      s_d.prompt_go = 1'b0;
      if (c >= "a" && c <= "z") begin
         c = c - CASE_GAP;
      end
      if (c >= "0" && c <= "9") begin
         is_dig = 1'b1;
         is_hex = 1'b1;
         d = {4'h0, c[3:0]};
         nib = c[3:0];
      end else if (c >= "A" && c <= "F") begin
         is_hex = 1'b1;
         nib = c[3:0] + HEX_ADJ;
      end
      // The settings live in nonvolatile storage, so they are fetched at power up.
      if (s_q.ph == PH_INIT) begin
         s_d.cfg = nv_cfg;
         s_d.tries = nv_cfg.det_tries;
         s_d.rx_dis_act = nv_cfg.rx_off;
         if (nv_cfg.det_tries == 4'h0) begin
            s_d.ph = PH_CMD;
            s_d.hdr_go = nv_cfg.hdr_on;
         end else begin
            s_d.ph = PH_DET;
         end
      end
      if (s_q.ph == PH_DET) begin
         if (baud_lock) begin
            s_d.ph = PH_CMD;
            s_d.hdr_go = s_q.cfg.hdr_on;
         end else if (baud_fail) begin
            s_d.tries = s_q.tries - 4'h1;
            if (s_q.tries == 4'h1) begin
               s_d.ph = PH_CMD;
               s_d.hdr_go = s_q.cfg.hdr_on;
            end
         end
      end
      // The listening window runs from power up, whatever the detection phase.
      if (s_q.rx_dis_act && !s_q.rx_ign) begin
         if (rx_valid && rx_byte == "\r") begin
            s_d.rx_dis_act = 1'b0;
         end else if (s_q.win == RXWIN_CYC - 1) begin
            s_d.rx_ign = 1'b1;
         end else begin
            s_d.win = s_q.win + 32'h1;
         end
      end
      if (s_q.ph == PH_CMD) begin
         if (rx_valid) begin
            s_d.ipre = 40'h0;
            s_d.imin = 5'h00;
         end else if (s_q.cfg.tmo_min != 5'h00) begin
            s_d.ipre = s_q.ipre + 40'h1;
            if (s_q.ipre == 40'(MIN_CYC - 1)) begin
               s_d.ipre = 40'h0;
               s_d.imin = s_q.imin + 5'h01;
               if (s_q.imin + 5'h01 >= s_q.cfg.tmo_min) begin
                  s_d.ph = PH_LOG;
               end
            end
         end
      end
      if (s_q.ph == PH_CMD && rx_valid && !s_q.rx_ign) begin
         if (c == "\r") begin
            s_d.prompt_go = 1'b1;
            if (w0[31:16] == "SE") begin
               if (w1[31:8] == "DEF") begin
                  s_d.cfg = CFG_DEFAULT;
               end else if (w1[31:16] == "IN") begin
                  s_d.cfg.inc_cent = 16'(s_q.fl[0] * CENT) +
                     ((s_q.fdig == 2'h1) ? 16'(s_q.fl[1] * TENTH) : 16'(s_q.fl[1]));
               end else if (w1 == "RXOF") begin
                  s_d.cfg.rx_off = 1'b1;
               end else if (w1 == {"RX", "ON"}) begin
                  s_d.cfg.rx_off = 1'b0;
               end else if (w1[31:24] == "D") begin
                  if (s_q.hxn == 2'h2) begin
                     s_d.cfg.det_tries = s_q.hx[7:4];
                     s_d.cfg.det_code = s_q.hx[3:0];
                  end
               end else if (w1[31:24] == "T") begin
                  if (s_q.fl[0] <= {3'h0, TMO_MAX} && s_q.fi == 2'h0) begin
                     s_d.cfg.tmo_min = s_q.fl[0][4:0];
                  end
               end else if (w1[31:16] == "SC") begin
                  if (w2[31:16] == "DA") begin
                     s_d.cfg.show_date = 1'b1;
                  end else if (w2[31:8] == "NOD") begin
                     s_d.cfg.show_date = 1'b0;
                  end else if (w2[31:8] == "NOT") begin
                     s_d.cfg.show_time = 1'b0;
                  end else if (w2[31:24] == "T") begin
                     s_d.cfg.show_time = 1'b1;
                  end else if (w2[31:24] == "D") begin
                     s_d.cfg.scan_dly = s_q.fl[0];
                  end
               end else if (w1[31:16] == "ST") begin
                  if (w2[31:8] == "NOH") begin
                     s_d.cfg.hdr_on = 1'b0;
                  end else if (w2[31:24] == "H") begin
                     s_d.cfg.hdr_on = 1'b1;
                  end else if (w2[31:24] == "D") begin
                     s_d.cfg.start_dly = s_q.fl[0];
                  end
               end else if (w1[31:24] == "A") begin
                  if (w2[31:16] == "OF") begin
                     s_d.cfg.ana_on = 1'b0;
                  end else if (w2[31:24] == "O") begin
                     s_d.cfg.ana_on = 1'b1;
                  end else if (w2[31:24] == "1") begin
                     s_d.cfg.ana_two = 1'b0;
                  end else if (w2[31:24] == "2") begin
                     s_d.cfg.ana_two = 1'b1;
                  end
               end
            end else if (w0[31:24] == "T" && (w0[23:16] == NUL || w0[23:16] == "I")) begin
               if (s_q.fi >= 2'h2 && s_q.fl[0] < HOUR_LIM) begin
                  s_d.rtc_ld = 1'b1;
                  s_d.rtc = {s_q.fl[0], s_q.fl[1], s_q.fl[2], s_q.fl[3]};
               end
            end else if (w0[31:16] == "DA") begin
               if (s_q.fi == 2'h2) begin
                  s_d.cal_ld = 1'b1;
                  s_d.cal = {s_q.fl[0], s_q.fl[1], s_q.fl[2]};
               end
            end else if (w0 == "DUMP") begin
               s_d.dump_go = 1'b1;
            end else if (w0 == "INIT") begin
               s_d.clr_go = 1'b1;
            end else if (w0[31:24] == "D" && w1[31:24] == "M") begin
               s_d.mstat_go = 1'b1;
            end
            s_d.wd = '0;
            s_d.wi = 2'h0;
            s_d.ci = 3'h0;
            s_d.fl = '0;
            s_d.fi = 2'h0;
            s_d.fdig = 2'h0;
            s_d.hx = 8'h00;
            s_d.hxn = 2'h0;
         end else if (c == " ") begin
            if (s_q.ci != 3'h0 && s_q.wi != 2'h3) begin
               s_d.wi = s_q.wi + 2'h1;
            end
            s_d.ci = 3'h0;
            s_d.fl = '0;
            s_d.fi = 2'h0;
            s_d.fdig = 2'h0;
            s_d.hx = 8'h00;
            s_d.hxn = 2'h0;
         end else begin
            // Only four letters of each word are kept; that is enough to tell commands apart.
            if (s_q.wi != 2'h3 && s_q.ci != 3'h4) begin
               s_d.wd[s_q.wi][(3 - s_q.ci) * 8 +: 8] = c;
               s_d.ci = s_q.ci + 3'h1;
            end
            if (is_dig) begin
               s_d.fl[s_q.fi] = 8'(s_q.fl[s_q.fi] * DEC + d);
               if (s_q.fi == 2'h1 && s_q.fdig != 2'h3) begin
                  s_d.fdig = s_q.fdig + 2'h1;
               end
            end else if ((c == ":" || c == "/" || c == ".") && s_q.fi != 2'h3) begin
               s_d.fi = s_q.fi + 2'h1;
            end
            if (is_hex) begin
               s_d.hx = {s_q.hx[3:0], nib};
               if (s_q.hxn != 2'h3) begin
                  s_d.hxn = s_q.hxn + 2'h1;
               end
            end
         end
      end
      // One prescaler serves both delays because they never overlap.
      busy = !s_q.sens_on || s_q.scan_wait;
      tgt = s_q.sens_on ? s_q.cfg.scan_dly : s_q.cfg.start_dly;
      if (s_q.ph != PH_INIT && busy) begin
         if (s_q.dcnt == tgt) begin
            s_d.dcnt = 8'h00;
            s_d.spre = 32'h0;
            if (!s_q.sens_on) begin
               s_d.sens_on = 1'b1;
            end else begin
               s_d.scan_wait = 1'b0;
               s_d.scan_go = 1'b1;
            end
         end else if (s_q.spre == STEP_CYC - 1) begin
            s_d.spre = 32'h0;
            s_d.dcnt = s_q.dcnt + 8'h01;
         end else begin
            s_d.spre = s_q.spre + 32'h1;
         end
      end else if (s_q.sens_on && sample_tick) begin
         s_d.scan_wait = 1'b1;
      end
      if (s_q.ph == PH_LOG && press_valid) begin
         diff = (press_cent >= s_q.last_p) ? press_cent - s_q.last_p : s_q.last_p - press_cent;
         if (!s_q.have_p || diff >= s_q.cfg.inc_cent) begin
            s_d.log_store = 1'b1;
            s_d.cast_mark = !s_q.have_p;
            s_d.last_p = press_cent;
            s_d.have_p = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{ph: PH_INIT, cfg: CFG_DEFAULT, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign cfg = s_q.cfg;
   assign det_busy = (s_q.ph == PH_DET);
   assign baud_bps = rate_of(s_q.cfg.det_code);
   assign rx_ignore = s_q.rx_ign || (s_q.ph == PH_LOG);
   assign logging = (s_q.ph == PH_LOG);
   assign sensor_pwr = s_q.sens_on;
   assign scan_go = s_q.scan_go;
   assign log_store = s_q.log_store;
   assign cast_mark = s_q.cast_mark;
   assign dump_go = s_q.dump_go;
   assign mem_clear_go = s_q.clr_go;
   assign mem_stat_go = s_q.mstat_go;
   assign rtc_load = s_q.rtc_ld;
   assign rtc_set = s_q.rtc;
   assign cal_load = s_q.cal_ld;
   assign cal_set = s_q.cal;
   assign hdr_go = s_q.hdr_go;
   assign prompt_go = s_q.prompt_go;
   assign ana1_en = s_q.cfg.ana_on;
   assign ana2_en = s_q.cfg.ana_on && s_q.cfg.ana_two;
endmodule : sci_cmd_interp

//--- dv/sci_cmd_chk.sv
`timescale 1ns/1ps
module sci_cmd_chk (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire sci_pkg::sci_cfg_s cfg,
   input wire logic [15:0] baud_bps,
   input wire logic rx_ignore,
   input wire logic logging,
   input wire logic sensor_pwr,
   input wire logic scan_go,
   input wire logic log_store,
   input wire logic cast_mark,
   input wire logic rtc_load,
   input wire sci_pkg::sci_clk_s rtc_set,
   input wire logic prompt_go,
   input wire logic ana1_en,
   input wire logic ana2_en
);
   import sci_pkg::*;
   function automatic logic [15:0] exp_bps(input logic [3:0] c);
      case (c)
         4'h1, 4'h2: exp_bps = BPS_1200;
         4'h3: exp_bps = BPS_2400;
         4'h4: exp_bps = BPS_4800;
         4'h6: exp_bps = BPS_19200;
         4'h7: exp_bps = BPS_38400;
         default: exp_bps = BPS_9600;
      endcase
   endfunction : exp_bps
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   prompt_after_cr_a: assert property (
      prompt_go |-> $past(rx_valid) && $past(rx_byte) == 8'h0D)
      else $error("prompt without a return");
   time_hour_a: assert property (rtc_load |-> rtc_set.hour < HOUR_LIM && prompt_go)
      else $error("clock load out of range");
   cast_first_a: assert property (cast_mark |-> log_store && logging)
      else $error("cast mark without store");
   store_logging_a: assert property (log_store |-> logging)
      else $error("store outside logging");
   logging_hold_a: assert property (logging |=> logging)
      else $error("logging left without reset");
   logging_deaf_a: assert property (logging |-> rx_ignore)
      else $error("host heard while logging");
   baud_map_a: assert property (baud_bps == exp_bps(cfg.det_code))
      else $error("fallback rate wrong");
   analog_off_a: assert property (!cfg.ana_on |-> !ana1_en && !ana2_en)
      else $error("analog enabled while off");
   analog_two_a: assert property (ana2_en |-> ana1_en && cfg.ana_two)
      else $error("second channel without first");
   scan_power_a: assert property (scan_go |-> sensor_pwr)
      else $error("scan without sensor power");
   timeout_max_a: assert property (cfg.tmo_min <= TMO_MAX)
      else $error("timeout above limit");
endmodule : sci_cmd_chk

bind sci_cmd_interp sci_cmd_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
   .rx_valid(rx_valid), .rx_byte(rx_byte), .cfg(cfg), .baud_bps(baud_bps),
   .rx_ignore(rx_ignore), .logging(logging), .sensor_pwr(sensor_pwr), .scan_go(scan_go),
   .log_store(log_store), .cast_mark(cast_mark), .rtc_load(rtc_load), .rtc_set(rtc_set),
   .prompt_go(prompt_go), .ana1_en(ana1_en), .ana2_en(ana2_en));

//--- dv/sci_host_model.sv
`timescale 1ns/1ps
module sci_host_model (
   input wire logic core_clk,
   output logic rx_valid,
   output logic [7:0] rx_byte
);
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'hFF;
   end
   // One whole 8N1 character per strobe; the byte is scrambled after so stale data never matches.
   task automatic send_char(input logic [7:0] c);
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_byte = c;
      @(negedge core_clk);
      rx_valid = 1'b0;
      rx_byte = ~c;
   endtask : send_char
   task automatic send_line(input string s);
      for (int i = 0; i < s.len(); i++) begin
         send_char(s[i]);
      end
      send_char(8'h0D);
   endtask : send_line
endmodule : sci_host_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import sci_pkg::*;
   localparam logic [8:0] EV_P = 9'h100, EV_RTC = 9'h080, EV_CAL = 9'h040, EV_DMP = 9'h020;
   localparam logic [8:0] EV_CLR = 9'h010, EV_MST = 9'h008, EV_HDR = 9'h004, EV_LOG = 9'h002;
   localparam logic [8:0] EV_CAST = 9'h001;
   typedef struct packed {
      logic [8:0] ev;
      sci_cfg_s cfg;
      logic [31:0] val;
   } sci_note_s;
   logic core_clk, reset_n, rx_valid, baud_fail, baud_lock, sample_tick, press_valid;
   logic det_busy, rx_ignore, logging, sensor_pwr, scan_go, log_store, cast_mark, dump_go;
   logic mem_clear_go, mem_stat_go, rtc_load, cal_load, hdr_go, prompt_go, ana1_en, ana2_en;
   logic [7:0] rx_byte;
   logic [15:0] press_cent, baud_bps;
   sci_cfg_s nv_cfg, cfg, m_cfg;
   sci_clk_s rtc_set;
   sci_date_s cal_set;
   sci_note_s notes[$];
   int bad_count = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'h44128847;
   sci_cmd_interp #(.RXWIN_CYC(20), .STEP_CYC(4), .MIN_CYC(10)) dut (.core_clk(core_clk),
      .reset_n(reset_n), .rx_valid(rx_valid), .rx_byte(rx_byte), .baud_fail(baud_fail),
      .baud_lock(baud_lock), .sample_tick(sample_tick), .press_valid(press_valid),
      .press_cent(press_cent), .nv_cfg(nv_cfg), .cfg(cfg), .det_busy(det_busy),
      .baud_bps(baud_bps), .rx_ignore(rx_ignore), .logging(logging), .sensor_pwr(sensor_pwr),
      .scan_go(scan_go), .log_store(log_store), .cast_mark(cast_mark), .dump_go(dump_go),
      .mem_clear_go(mem_clear_go), .mem_stat_go(mem_stat_go), .rtc_load(rtc_load),
      .rtc_set(rtc_set), .cal_load(cal_load), .cal_set(cal_set), .hdr_go(hdr_go),
      .prompt_go(prompt_go), .ana1_en(ana1_en), .ana2_en(ana2_en));
   sci_host_model u_host (.core_clk(core_clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic tally_and_finish();
      if (bad_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [15:0] tb_bps(input logic [3:0] c);
      case (c)
         4'h1, 4'h2: return 16'h04B0;
         4'h3: return 16'h0960;
         4'h4: return 16'h12C0;
         4'h6: return 16'h4B00;
         4'h7: return 16'h9600;
         default: return 16'h2580;
      endcase
   endfunction : tb_bps
   task automatic cycles(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cycles
   task automatic note(input logic [8:0] ev, input logic [31:0] v);
      notes.push_back('{ev, m_cfg, v});
   endtask : note
   // A result that never comes must not hang the run.
   task automatic wait_q();
      for (int i = 0; i < 60; i++) begin
         if (notes.size() == 0) return;
         @(negedge core_clk);
      end
      bad_count++;
      tally_and_finish();
   endtask : wait_q
   task automatic cmd(input string s, input logic [8:0] ev, input logic [31:0] v);
      note(EV_P | ev, v);
      u_host.send_line(s);
      wait_q();
   endtask : cmd
   task automatic do_reset(input sci_cfg_s nv);
      @(negedge core_clk);
      reset_n = 1'b0;
      nv_cfg = nv;
      m_cfg = nv;
      notes.delete();
      cycles(4);
      reset_n = 1'b1;
   endtask : do_reset
   task automatic press(input logic [15:0] v);
      press_cent = v;
      press_valid = 1'b1;
      @(negedge core_clk);
      press_valid = 1'b0;
      cycles(3);
   endtask : press
   always @(negedge core_clk) begin : mon
      logic [8:0] ev;
      sci_note_s n;
      ev = {prompt_go, rtc_load, cal_load, dump_go, mem_clear_go, mem_stat_go, hdr_go,
         log_store, cast_mark};
      if (reset_n === 1'b1 && ev !== 9'h000) begin
         if (notes.size() == 0) begin
            chk("unexpected", ev, 0);
         end else begin
            n = notes.pop_front();
            chk("events", ev, n.ev);
            chk("cfg", cfg, n.cfg);
            chk("value", rtc_load ? 32'(rtc_set) : 32'(cal_load ? 32'(cal_set) : 0),
               n.val);
         end
      end
   end
   initial begin
      #400000;
      bad_count++;
      tally_and_finish();
   end
   initial begin : main
      sci_cfg_s nv;
      int t_pwr, t_ign;
      logic [31:0] r;
      reset_n = 1'b0;
      baud_fail = 1'b0;
      baud_lock = 1'b0;
      sample_tick = 1'b0;
      press_valid = 1'b0;
      press_cent = 16'h0000;
      nv_cfg = CFG_DEFAULT;
      nv = CFG_DEFAULT;
      nv.det_tries = 4'h2;
      do_reset(nv);
      cycles(2);
      chk("det_busy", det_busy, 1);
      note(EV_HDR, 0);
      repeat (2) begin
         baud_fail = 1'b1;
         @(negedge core_clk);
         baud_fail = 1'b0;
         @(negedge core_clk);
      end
      wait_q();
      chk("det_busy", det_busy, 0);
      m_cfg.inc_cent = 16'h0032;
      cmd("SET INC .5", 0, 0);
      m_cfg.inc_cent = 16'h03E8;
      cmd("se inc 10", 0, 0);
      cmd("T 13:44:12", EV_RTC, 32'h0D2C0C00);
      cmd("TIME 23:59:59.99", EV_RTC, 32'h173B3B63);
      cmd("TIME 24:00:00", 0, 0);
      cmd("DATE 03/14/03", EV_CAL, 32'h00030E03);
      cmd("DUMP", EV_DMP, 0);
      cmd("INIT", EV_CLR, 0);
      cmd("dis m", EV_MST, 0);
      cmd("BOGUS LINE", 0, 0);
      for (int i = 0; i < 16; i++) begin
         r = xs();
         m_cfg.det_tries = r[3:0];
         m_cfg.det_code = 4'(i);
         cmd($sformatf("SE D %h%h", r[3:0], 4'(i)), 0, 0);
         chk("baud_bps", baud_bps, tb_bps(4'(i)));
      end
      m_cfg.rx_off = 1'b1;
      cmd({"SET RX", "OFF"}, 0, 0);
      m_cfg.rx_off = 1'b0;
      cmd({"set rx", "on"}, 0, 0);
      m_cfg.tmo_min = 5'h1E;
      cmd("SE T 30", 0, 0);
      cmd("SE T 31", 0, 0);
      m_cfg.scan_dly = 8'hFF;
      cmd("SE SC D 255", 0, 0);
      m_cfg.start_dly = 8'hC8;
      cmd("SET STARTUP DELAY 200", 0, 0);
      m_cfg.show_time = 1'b0;
      cmd("SE SC NOT", 0, 0);
      m_cfg.show_date = 1'b0;
      cmd("SE SC NOD", 0, 0);
      m_cfg.show_time = 1'b1;
      cmd("SE SC T", 0, 0);
      m_cfg.show_date = 1'b1;
      cmd("SE SC DA", 0, 0);
      m_cfg.ana_on = 1'b1;
      cmd("SE A O", 0, 0);
      m_cfg.ana_two = 1'b1;
      cmd("SE A 2", 0, 0);
      chk("ana", {ana1_en, ana2_en}, 2'b11);
      m_cfg.ana_two = 1'b0;
      cmd("SE A 1", 0, 0);
      chk("ana", {ana1_en, ana2_en}, 2'b10);
      m_cfg.ana_on = 1'b0;
      cmd("SE A OF", 0, 0);
      chk("ana", {ana1_en, ana2_en}, 2'b00);
      m_cfg.hdr_on = 1'b0;
      cmd("SE ST NOH", 0, 0);
      m_cfg.hdr_on = 1'b1;
      cmd("SE ST H", 0, 0);
      m_cfg = CFG_DEFAULT;
      cmd("SET DEFAULT", 0, 0);
      nv = CFG_DEFAULT;
      nv.det_tries = 4'h0;
      nv.rx_off = 1'b1;
      nv.hdr_on = 1'b0;
      nv.start_dly = 8'h02;
      do_reset(nv);
      t_pwr = 0;
      t_ign = 0;
      for (int i = 1; i <= 40; i++) begin
         @(negedge core_clk);
         if (sensor_pwr === 1'b1 && t_pwr == 0) t_pwr = i;
         if (rx_ignore === 1'b1 && t_ign == 0) t_ign = i;
      end
      chk("pwr_time", t_pwr >= 9 && t_pwr <= 11, 1);
      chk("ign_time", t_ign >= 20 && t_ign <= 23, 1);
      u_host.send_line("DUMP");
      cycles(10);
      nv = CFG_DEFAULT;
      nv.det_tries = 4'h3;
      nv.rx_off = 1'b1;
      nv.tmo_min = 5'h03;
      nv.scan_dly = 8'h01;
      do_reset(nv);
      cycles(2);
      u_host.send_char(8'h0D);
      note(EV_HDR, 0);
      baud_lock = 1'b1;
      @(negedge core_clk);
      baud_lock = 1'b0;
      wait_q();
      cmd("xyz", 0, 0);
      cycles(8);
      chk("rx_ignore", rx_ignore, 0);
      for (int i = 0; i < 80 && logging !== 1'b1; i++) @(negedge core_clk);
      chk("logging", logging, 1);
      if (bad_count != 0) tally_and_finish();
      sample_tick = 1'b1;
      @(negedge core_clk);
      sample_tick = 1'b0;
      t_pwr = 0;
      for (int i = 1; i <= 20 && t_pwr == 0; i++) begin
         @(negedge core_clk);
         if (scan_go === 1'b1) t_pwr = i;
      end
      chk("scan_time", t_pwr >= 4 && t_pwr <= 8, 1);
      note(EV_LOG | EV_CAST, 0);
      press(16'h03E8);
      press(16'h044B);
      note(EV_LOG, 0);
      press(16'h0384);
      u_host.send_line("SE T 0");
      cycles(5);
      wait_q();
      chk("logging", logging, 1);
      tally_and_finish();
   end
endmodule : tb_top
